// >>> rtl/tws_pkg.sv
// Shared constants and types of the two-wire register slave.
// Assumes: compiled before every other file of the block.
package tws_pkg;

    // Widths of the register address and data word
    localparam int TWS_ADDR_W = 8;
    localparam int TWS_DATA_W = 16;
    localparam int TWS_BYTE_W = 8;
    localparam int TWS_CNT_W  = 3;

    // Last bit position inside a byte
    localparam logic [2:0] TWS_LAST_BIT = 3'h7;

    // Reset values
    localparam logic [7:0]  TWS_ADDR_RST = 8'h00;
    localparam logic [15:0] TWS_DATA_RST = 16'h0000;
    localparam logic [7:0]  TWS_BYTE_RST = 8'h00;

    // Bus identity; value is arbitrary, bit 0 is the direction flag
    localparam logic [7:0] TWS_DEV_ID_DEF = 8'h5A;

    // Link-side transfer states, one-hot
    typedef enum logic [9:0] {
        TWS_ST_IDLE   = 10'h001,
        TWS_ST_DEVID  = 10'h002,
        TWS_ST_DEVACK = 10'h004,
        TWS_ST_REGADR = 10'h008,
        TWS_ST_ADRACK = 10'h010,
        TWS_ST_WRBYTE = 10'h020,
        TWS_ST_WRACK  = 10'h040,
        TWS_ST_RDWAIT = 10'h080,
        TWS_ST_RDBYTE = 10'h100,
        TWS_ST_RDACK  = 10'h200
    } tws_state_e;

endpackage

// >>> rtl/tws_xfer_if.sv
// Interface carrying register requests from the link domain to the
// system domain and read answers back.
// Assumes: fields are held stable while their toggle crosses.
`timescale 1ns/1ps
`default_nettype none
interface tws_xfer_if;
    import tws_pkg::*;
    logic                  reqTgl;   // Toggles once per request
    logic                  reqWrite; // High for write, low for read
    logic [TWS_ADDR_W-1:0] reqAddr;  // Register address
    logic [TWS_DATA_W-1:0] reqData;  // Write word
    logic                  ackTgl;   // Toggles once per read answer
    logic [TWS_DATA_W-1:0] rspData;  // Read word

    // Link end issues requests
    modport link (output reqTgl, reqWrite, reqAddr, reqData,
                  input ackTgl, rspData);
    // System end serves them
    modport regs (input reqTgl, reqWrite, reqAddr, reqData,
                  output ackTgl, rspData);
endinterface
`default_nettype wire

// >>> rtl/tws_reg_port.sv
// System-clock register port: turns crossed link requests into
// one-cycle read and write strobes and returns read words.
// Assumes: register file answers a read one cycle after the strobe.
`timescale 1ns/1ps
`default_nettype none
module tws_reg_port (
    input  wire logic                           clk_sys,
    input  wire logic                           reset_n,
    tws_xfer_if.regs                            xfer,
    output var  logic                           regWrEn,
    output var  logic                           regRdEn,
    output var  logic [tws_pkg::TWS_ADDR_W-1:0] regAddr,
    output var  logic [tws_pkg::TWS_DATA_W-1:0] regWrData,
    input  wire logic [tws_pkg::TWS_DATA_W-1:0] regRdData
);
    import tws_pkg::*;

    // ***************************************************
    // Request toggle crossing
    // ***************************************************
    logic reqMeta_reg;  // First stage, read only by second
    logic reqSync_reg;  // Second stage
    logic reqPrev_reg;  // Last seen value
    logic rdPend_reg;   // Read answer due this cycle
    logic reqNew;       // New request arrived

    // Two-stage synchroniser and edge history
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            reqMeta_reg <= 1'b0;
            reqSync_reg <= 1'b0;
            reqPrev_reg <= 1'b0;
        end else begin
            reqMeta_reg <= xfer.reqTgl;
            reqSync_reg <= reqMeta_reg;
            reqPrev_reg <= reqSync_reg;
        end
    end

    assign reqNew = reqSync_reg ^ reqPrev_reg;

    // ***************************************************
    // Strobes towards the register file
    // ***************************************************
    // Fields are stable by the time the toggle is seen
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            regWrEn   <= 1'b0;
            regRdEn   <= 1'b0;
            regAddr   <= TWS_ADDR_RST;
            regWrData <= TWS_DATA_RST;
        end else begin
            regWrEn <= reqNew & xfer.reqWrite;
            regRdEn <= reqNew & ~xfer.reqWrite;
            if (reqNew) begin
                regAddr   <= xfer.reqAddr;
                regWrData <= xfer.reqData;
            end
        end
    end

    // ***************************************************
    // Read answer back to the link
    // ***************************************************
    // Capture the word and toggle the answer flag
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            rdPend_reg   <= 1'b0;
            xfer.rspData <= TWS_DATA_RST;
            xfer.ackTgl  <= 1'b0;
        end else begin
            rdPend_reg <= regRdEn;
            if (rdPend_reg) begin
                xfer.rspData <= regRdData;
                xfer.ackTgl  <= ~xfer.ackTgl;
            end
        end
    end

endmodule
`default_nettype wire

// >>> rtl/tws_two_wire_register_slave.sv
// Two-wire serial control port, slave only, 8-bit register
// address and 16-bit words, with auto-increment.
// Assumes: clk_link runs free and well above the serial clock;
// the pull-up and wire resolution sit outside.
//
// Functional notes
// - Slave only; one driven by releasing data
// - First byte is identity plus direction bit
// - Data falling while clock high starts
// - Shift eight identity bits, MSB first
// - Matching identity acknowledged by holding data low
// - Mismatch or read when write-only: idle
// - Data rising while clock high stops
// - Complete sequence returns to idle
// - Out-of-order start or stop abandons transfer
// - Register address byte follows the identity
// - Every register readable over the port
// - Read: address, restart, MSB acked, LSB nacked
// - Single and auto-incrementing multiple transfers
// - Read may continue from last address
`timescale 1ns/1ps
`default_nettype none
module tws_two_wire_register_slave #(
    parameter logic [7:0] DEV_ID = tws_pkg::TWS_DEV_ID_DEF
) (
    input  wire logic                           clk_sys,
    input  wire logic                           reset_n,
    input  wire logic                           clk_link,
    input  wire logic                           sclIn,
    input  wire logic                           sdaIn,
    output var  logic                           sdaOut,
    output var  logic                           sdaOe,
    input  wire logic                           writeOnly,
    output var  logic                           regWrEn,
    output var  logic                           regRdEn,
    output var  logic [tws_pkg::TWS_ADDR_W-1:0] regAddr,
    output var  logic [tws_pkg::TWS_DATA_W-1:0] regWrData,
    input  wire logic [tws_pkg::TWS_DATA_W-1:0] regRdData
);
    import tws_pkg::*;

    // ***************************************************
    // Declarations
    // ***************************************************
    localparam int NPIN = 3;              // Synchronised inputs

    logic                  linkRstMeta;   // Reset release stage 1
    logic                  linkRstN;      // Link-domain reset
    logic [NPIN-1:0]       pinRaw;        // Pins before sync
    logic [NPIN-1:0]       pinMeta;       // First sync stage
    logic [NPIN-1:0]       pinSync;       // Second sync stage
    logic                  sclPrev;       // Clock one cycle ago
    logic                  sdaPrev;       // Data one cycle ago
    logic                  sclS;          // Synchronised clock
    logic                  sdaS;          // Synchronised data
    logic                  woS;           // Synchronised write-only
    logic                  sclRise;       // Clock rising
    logic                  sclFall;       // Clock falling
    logic                  startSeen;     // Start condition
    logic                  stopSeen;      // Stop condition
    logic                  ackMeta;       // Answer sync stage 1
    logic                  ackSync;       // Answer sync stage 2
    logic                  ackPrev;       // Answer last value
    logic                  rspSeen;       // Read answer arrived

    tws_state_e            state_reg;     // Transfer state
    logic [TWS_CNT_W-1:0]  bitCnt_reg;    // Bits of current byte
    logic                  byteDone_reg;  // Eighth bit clocked
    logic [TWS_BYTE_W-1:0] shift_reg;     // Receive shifter
    logic [TWS_BYTE_W-1:0] txByte_reg;    // Transmit shifter
    logic [TWS_DATA_W-1:0] txWord_reg;    // Word being sent
    logic [TWS_BYTE_W-1:0] hiByte_reg;    // Received MSB
    logic                  hiPhase_reg;   // Next byte is MSB
    logic                  rwRead_reg;    // Current direction
    logic                  mstAck_reg;    // Master acknowledged
    logic                  rspReady_reg;  // Read word available
    logic [TWS_ADDR_W-1:0] addrPtr_reg;   // Held register address
    logic                  sdaOe_reg;     // Pull data low

    tws_xfer_if xfer ();                  // Crossing bundle

    // ***************************************************
    // Decode helpers
    // ***************************************************
    // States in which the master sends bits
    function automatic logic isRx(input tws_state_e s);
        isRx = (s == TWS_ST_DEVID) || (s == TWS_ST_REGADR) ||
               (s == TWS_ST_WRBYTE);
    endfunction

    // Start allowed only when idle or between bytes; a repeated start
    // always follows one clock rise, so the first bit may be counted
    function automatic logic startOk(input tws_state_e s,
                                     input logic [2:0] n,
                                     input logic d);
        startOk = (s == TWS_ST_IDLE) ||
                  (isRx(s) && (n <= 3'h1) && !d);
    endfunction

    // ***************************************************
    // Link reset and pin synchronisers
    // ***************************************************
    // Reset asserts at once and releases on clk_link
    always_ff @(posedge clk_link or negedge reset_n) begin
        if (!reset_n) begin
            linkRstMeta <= 1'b0;
            linkRstN    <= 1'b0;
        end else begin
            linkRstMeta <= 1'b1;
            linkRstN    <= linkRstMeta;
        end
    end

    assign pinRaw = {writeOnly, sdaIn, sclIn};

    // Two flip-flops per incoming pin
    genvar gi;
    generate
        for (gi = 0; gi < NPIN; gi++) begin : g_sync
            always_ff @(posedge clk_link or negedge linkRstN) begin
                if (!linkRstN) begin
                    pinMeta[gi] <= 1'b1;
                    pinSync[gi] <= 1'b1;
                end else begin
                    pinMeta[gi] <= pinRaw[gi];
                    pinSync[gi] <= pinMeta[gi];
                end
            end
        end
    endgenerate

    assign sclS = pinSync[0];
    assign sdaS = pinSync[1];
    assign woS  = pinSync[2];

    // History of the synchronised bus lines
    always_ff @(posedge clk_link or negedge linkRstN) begin
        if (!linkRstN) begin
            sclPrev <= 1'b1;
            sdaPrev <= 1'b1;
        end else begin
            sclPrev <= sclS;
            sdaPrev <= sdaS;
        end
    end

    assign sclRise = sclS & ~sclPrev;
    assign sclFall = ~sclS & sclPrev;
    assign startSeen = sclS & sclPrev & sdaPrev & ~sdaS;
    assign stopSeen = sclS & sclPrev & ~sdaPrev & sdaS;

    // ***************************************************
    // Read answer crossing
    // ***************************************************
    // Answer toggle into the link domain
    always_ff @(posedge clk_link or negedge linkRstN) begin
        if (!linkRstN) begin
            ackMeta <= 1'b0;
            ackSync <= 1'b0;
            ackPrev <= 1'b0;
        end else begin
            ackMeta <= xfer.ackTgl;
            ackSync <= ackMeta;
            ackPrev <= ackSync;
        end
    end

    assign rspSeen = ackSync ^ ackPrev;

    // ***************************************************
    // Transfer engine
    // ***************************************************
    // Bus states, shifters, address pointer and requests
    always_ff @(posedge clk_link or negedge linkRstN) begin
        if (!linkRstN) begin
            state_reg     <= TWS_ST_IDLE;
            bitCnt_reg    <= '0;
            byteDone_reg  <= 1'b0;
            shift_reg     <= TWS_BYTE_RST;
            txByte_reg    <= TWS_BYTE_RST;
            txWord_reg    <= TWS_DATA_RST;
            hiByte_reg    <= TWS_BYTE_RST;
            hiPhase_reg   <= 1'b1;
            rwRead_reg    <= 1'b0;
            mstAck_reg    <= 1'b0;
            rspReady_reg  <= 1'b0;
            addrPtr_reg   <= TWS_ADDR_RST;
            sdaOe_reg     <= 1'b0;
            xfer.reqTgl   <= 1'b0;
            xfer.reqWrite <= 1'b0;
            xfer.reqAddr  <= TWS_ADDR_RST;
            xfer.reqData  <= TWS_DATA_RST;
        end else begin
            if (stopSeen) begin
                state_reg <= TWS_ST_IDLE;
                sdaOe_reg <= 1'b0;
            end else if (startSeen) begin
                sdaOe_reg    <= 1'b0;
                bitCnt_reg   <= '0;
                byteDone_reg <= 1'b0;
                if (startOk(state_reg, bitCnt_reg, byteDone_reg)) begin
                    state_reg <= TWS_ST_DEVID;
                end else begin
                    state_reg <= TWS_ST_IDLE;
                end
            end else if (sclRise) begin
                if (isRx(state_reg)) begin
                    shift_reg    <= {shift_reg[6:0], sdaS};
                    bitCnt_reg   <= bitCnt_reg + 3'h1;
                    byteDone_reg <= (bitCnt_reg == TWS_LAST_BIT);
                end else if (state_reg == TWS_ST_RDBYTE) begin
                    bitCnt_reg   <= bitCnt_reg + 3'h1;
                    byteDone_reg <= (bitCnt_reg == TWS_LAST_BIT);
                end else if (state_reg == TWS_ST_RDACK) begin
                    mstAck_reg <= ~sdaS;
                end
            end else if (sclFall) begin
                case (state_reg)
                    // Identity byte complete
                    TWS_ST_DEVID: begin
                        if (byteDone_reg) begin
                            byteDone_reg <= 1'b0;
                            if (shift_reg[7:1] == DEV_ID[7:1] &&
                                !(shift_reg[0] && woS)) begin
                                state_reg  <= TWS_ST_DEVACK;
                                sdaOe_reg  <= 1'b1;
                                rwRead_reg <= shift_reg[0];
                                if (shift_reg[0]) begin
                                    xfer.reqTgl   <= ~xfer.reqTgl;
                                    xfer.reqWrite <= 1'b0;
                                    xfer.reqAddr  <= addrPtr_reg;
                                    rspReady_reg  <= 1'b0;
                                end
                            end else begin
                                state_reg <= TWS_ST_IDLE;
                            end
                        end
                    end
                    // End of identity acknowledge
                    TWS_ST_DEVACK: begin
                        sdaOe_reg   <= 1'b0;
                        hiPhase_reg <= 1'b1;
                        if (rwRead_reg) begin
                            state_reg <= TWS_ST_RDWAIT;
                        end else begin
                            state_reg <= TWS_ST_REGADR;
                        end
                    end
                    TWS_ST_REGADR: begin
                        if (byteDone_reg) begin
                            byteDone_reg <= 1'b0;
                            addrPtr_reg  <= shift_reg;
                            state_reg    <= TWS_ST_ADRACK;
                            sdaOe_reg    <= 1'b1;
                        end
                    end
                    // End of address acknowledge
                    TWS_ST_ADRACK: begin
                        sdaOe_reg   <= 1'b0;
                        hiPhase_reg <= 1'b1;
                        state_reg   <= TWS_ST_WRBYTE;
                    end
                    // Data byte from the master
                    TWS_ST_WRBYTE: begin
                        if (byteDone_reg) begin
                            byteDone_reg <= 1'b0;
                            sdaOe_reg    <= 1'b1;
                            state_reg    <= TWS_ST_WRACK;
                            hiPhase_reg  <= ~hiPhase_reg;
                            if (hiPhase_reg) begin
                                hiByte_reg <= shift_reg;
                            end else begin
                                xfer.reqTgl   <= ~xfer.reqTgl;
                                xfer.reqWrite <= 1'b1;
                                xfer.reqAddr  <= addrPtr_reg;
                                xfer.reqData  <= {hiByte_reg, shift_reg};
                                addrPtr_reg   <= addrPtr_reg + 8'h01;
                            end
                        end
                    end
                    // End of data acknowledge
                    TWS_ST_WRACK: begin
                        sdaOe_reg <= 1'b0;
                        state_reg <= TWS_ST_WRBYTE;
                    end
                    // Send bit by pulling or releasing
                    TWS_ST_RDBYTE: begin
                        if (byteDone_reg) begin
                            byteDone_reg <= 1'b0;
                            sdaOe_reg    <= 1'b0;
                            state_reg    <= TWS_ST_RDACK;
                        end else begin
                            txByte_reg <= {txByte_reg[6:0], 1'b0};
                            sdaOe_reg  <= ~txByte_reg[6];
                        end
                    end
                    TWS_ST_RDACK: begin
                        bitCnt_reg <= '0;
                        if (!hiPhase_reg) begin
                            addrPtr_reg <= addrPtr_reg + 8'h01;
                        end
                        if (!mstAck_reg) begin
                            state_reg <= TWS_ST_IDLE;
                        end else if (hiPhase_reg) begin
                            hiPhase_reg <= 1'b0;
                            txByte_reg  <= txWord_reg[7:0];
                            sdaOe_reg   <= ~txWord_reg[7];
                            state_reg   <= TWS_ST_RDBYTE;
                        end else begin
                            hiPhase_reg   <= 1'b1;
                            xfer.reqTgl   <= ~xfer.reqTgl;
                            xfer.reqWrite <= 1'b0;
                            xfer.reqAddr  <= addrPtr_reg + 8'h01;
                            rspReady_reg  <= 1'b0;
                            state_reg     <= TWS_ST_RDWAIT;
                        end
                    end
                    default: begin
                    end
                endcase
            end else if (state_reg == TWS_ST_RDWAIT && rspReady_reg) begin
                txWord_reg <= xfer.rspData;
                txByte_reg <= xfer.rspData[15:8];
                sdaOe_reg  <= ~xfer.rspData[15];
                bitCnt_reg <= '0;
                state_reg  <= TWS_ST_RDBYTE;
            end
            // Arrival of an answer wins over its clear
            if (rspSeen) begin
                rspReady_reg <= 1'b1;
            end
        end
    end

    // ***************************************************
    // Pin drivers
    // ***************************************************
    // Data is only ever pulled low, never driven high
    always_ff @(posedge clk_link or negedge linkRstN) begin
        if (!linkRstN) begin
            sdaOut <= 1'b0;
            sdaOe  <= 1'b0;
        end else begin
            sdaOut <= 1'b0;
            sdaOe  <= sdaOe_reg;
        end
    end

    // ***************************************************
    // System-side register port
    // ***************************************************
    tws_reg_port u_reg_port (
        .clk_sys   (clk_sys),
        .reset_n   (reset_n),
        .xfer      (xfer.regs),
        .regWrEn   (regWrEn),
        .regRdEn   (regRdEn),
        .regAddr   (regAddr),
        .regWrData (regWrData),
        .regRdData (regRdData)
    );

endmodule
`default_nettype wire

// >>> verification/tws_chk.sv
// Port assertions of the two-wire register slave.
// Assumes: bound into the slave top; sdaOe changes checked on clk_link, sdaOut checked on clk_sys.
`timescale 1ns/1ps
`default_nettype none
module tws_chk (
    input wire logic        clk_sys,
    input wire logic        reset_n,
    input wire logic        clk_link,
    input wire logic        sclIn,
    input wire logic        sdaOe,
    input wire logic        sdaOut,
    input wire logic        regWrEn,
    input wire logic        regRdEn,
    input wire logic [7:0]  regAddr,
    input wire logic [15:0] regWrData
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    a_wr_pulse: assert property (regWrEn |=> !regWrEn) else $error("long write");
    a_rd_pulse: assert property (regRdEn |=> !regRdEn) else $error("long read");
    a_one_strobe: assert property (!(regWrEn && regRdEn)) else $error("two strobes");
    a_wr_gap: assert property (regWrEn |=> (!(regWrEn || regRdEn))[*8]) else $error("gap");
    a_sda_zero: assert property (sdaOut == 1'b0) else $error("data driven high");
    a_addr_hold: assert property (!(regWrEn || regRdEn) |-> $stable(regAddr))
        else $error("address moved");
    a_data_hold: assert property (!(regWrEn || regRdEn) |-> $stable(regWrData))
        else $error("word moved");
    a_sda_edge: assert property (@(posedge clk_link) disable iff (!reset_n)
        $changed(sdaOe) |-> !sclIn) else $error("data moved, clock high");
    // Main traffic seen
    c_write: cover property (regWrEn);
    c_read: cover property (regRdEn);
    c_ack: cover property (@(posedge clk_link) $rose(sdaOe));
endmodule
bind tws_two_wire_register_slave tws_chk tws_chk_i (.clk_sys(clk_sys), .reset_n(reset_n),
    .clk_link(clk_link), .sclIn(sclIn), .sdaOe(sdaOe), .sdaOut(sdaOut), .regWrEn(regWrEn),
    .regRdEn(regRdEn), .regAddr(regAddr), .regWrData(regWrData));
`default_nettype wire

// >>> verification/tws_host.sv
// Bus master model driving the serial clock and data pins.
// Assumes: the data wire is resolved outside with a pull-up.
`timescale 1ns/1ps
`default_nettype none
module tws_host (
    output logic     scl,
    output logic     sdaMst,
    input wire logic sda
);
    localparam time T = 150ns; // Quarter bit, keeps each clock phase long
    initial begin
        scl = 1'b1;
        sdaMst = 1'b1;
    end
    // Data falls while clock high, also used as repeated start
    task automatic start();
        sdaMst = 1'b1; #T scl = 1'b1; #T sdaMst = 1'b0; #T scl = 1'b0;
    endtask
    // Data rises while clock high
    task automatic stop();
        #T sdaMst = 1'b0; #T scl = 1'b1; #T sdaMst = 1'b1; #T;
    endtask
    // Eight bits MSB first, then the acknowledge bit; released bits read high
    task automatic xbyte(input logic [7:0] d, input logic ack,
                         output logic [7:0] q, output logic a);
        logic [8:0] v;
        logic [8:0] r;
        v = {d, ack};
        for (int i = 8; i >= 0; i--) begin
            #T sdaMst = v[i]; #T scl = 1'b1; #T r[i] = sda; #T scl = 1'b0;
        end
        q = r[8:1];
        a = r[0];
    endtask
endmodule
`default_nettype wire

// >>> verification/testbench.sv
// Self-checking bench of the two-wire register slave.
// Assumes: host model drives the pins, the bench is the register file.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import tws_pkg::*;
    typedef struct {logic [7:0] a; logic [15:0] d; logic [15:0] e;} tws_row_s;
    localparam logic [7:0] ID0 = TWS_DEV_ID_DEF & 8'hFE; // Write identity
    logic clk_sys, clk_link, reset_n, writeOnly, sdaOut, sdaOe, regWrEn, regRdEn;
    logic [7:0] regAddr, b;
    logic [15:0] regWrData, regRdData, q, mem [256];
    wire logic scl, sdaMst, sda;
    int mismatches = 0, samplesChecked = 0, wrs = 0, k;
    tws_row_s rows [3] = '{'{8'h00, 16'h1234, 16'h1234}, '{8'h7F, 16'hABCD, 16'hABCD},
                          '{8'hFF, 16'h0001, 16'h0001}};
    assign sda = sdaMst & ~(sdaOe & ~sdaOut); // Open-drain wire with pull-up
    tws_two_wire_register_slave tws_two_wire_register_slave_i (.clk_sys(clk_sys),
        .reset_n(reset_n), .clk_link(clk_link), .sclIn(scl), .sdaIn(sda), .sdaOut(sdaOut),
        .sdaOe(sdaOe), .writeOnly(writeOnly), .regWrEn(regWrEn), .regRdEn(regRdEn),
        .regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData));
    tws_host tws_host_i (.scl(scl), .sdaMst(sdaMst), .sda(sda));
    initial begin clk_sys = 0; forever #5 clk_sys = ~clk_sys; end
    initial begin clk_link = 0; #3.3; forever #7.5 clk_link = ~clk_link; end
    // register file always clocked, so no clock-enable setting is needed
    // Register file, read word ready the cycle after the strobe
    always @(negedge clk_sys) begin
        if (regWrEn) begin mem[regAddr] <= regWrData; wrs <= wrs + 1; end
        if (regRdEn) regRdData <= mem[regAddr];
    end
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        samplesChecked++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic put(input logic [7:0] d, input logic ackExp);
        logic a;
        tws_host_i.xbyte(d, 1'b1, b, a);
        check(a, ackExp);
    endtask
    task automatic rdw(input logic last);
        logic a;
        tws_host_i.xbyte(8'hFF, 1'b0, q[15:8], a);
        tws_host_i.xbyte(8'hFF, last, q[7:0], a);
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d, input int n);
        tws_host_i.start();
        put(ID0, 1'b0);
        put(a, 1'b0);
        for (int j = 0; j < n; j++) begin put(8'((d + j) >> 8), 1'b0); put(8'(d + j), 1'b0); end
        tws_host_i.stop();
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", samplesChecked, mismatches);
        if (mismatches == 0 && samplesChecked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    initial begin #900us; mismatches++; test_done(); end
    initial begin
        reset_n = 0; writeOnly = 0; regRdData = 16'h0000;
        for (int i = 0; i < 256; i++) mem[i] = {8'hA5, 8'(i)};
        repeat (6) @(negedge clk_sys);
        check(sdaOe, 1'b0);
        check(regAddr, TWS_ADDR_RST);
        reset_n = 1;
        repeat (20) @(negedge clk_sys);
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].d, 1);
            check(mem[rows[i].a], rows[i].d);
            tws_host_i.start(); put(ID0, 0); put(rows[i].a, 0);
            tws_host_i.start(); put(ID0 | 8'h01, 0); rdw(1); tws_host_i.stop();
            check(q, rows[i].e);
        end
        $display("test rows done");
        k = wrs; wr(8'h10, 16'hBEEF, 2);
        check(16'(wrs - k), 16'h0002);
        check(mem[8'h11], 16'hBEF0);
        tws_host_i.start(); put(ID0 | 8'h01, 0); rdw(0);
        check(q, 16'hA512);
        rdw(1); tws_host_i.stop();
        check(q, 16'hA513);
        $display("test auto increment done");
        tws_host_i.start(); put(ID0 ^ 8'h02, 1); tws_host_i.stop();
        writeOnly = 1; tws_host_i.start(); put(ID0 | 8'h01, 1); tws_host_i.stop();
        writeOnly = 0; k = wrs;
        tws_host_i.start(); put(ID0, 0); put(8'h20, 0); put(8'h99, 0); tws_host_i.stop();
        check(16'(wrs - k), 16'h0000);
        $display("test refusals done");
        reset_n = 0; repeat (6) @(negedge clk_sys); reset_n = 1; repeat (20) @(negedge clk_sys);
        tws_host_i.start(); put(ID0 | 8'h01, 0); rdw(1); tws_host_i.stop();
        check(q, rows[0].d);
        $display("test second reset done");
        test_done();
    end
endmodule
`default_nettype wire
